// File: inc/panel_host_pkg.sv
package panel_host_pkg;

   // ************************************************************
   // core clock and derived time base
   // ************************************************************
   localparam int CORE_CLK_HZ = 100_000_000;
   localparam int CYC_PER_MS = CORE_CLK_HZ / 1000;

   // ************************************************************
   // video geometry, in pixel clocks and lines
   // ************************************************************
   localparam int LINE_ACTIVE_CLOCKS = 800;
   localparam int LINE_TOTAL_CLOCKS = 872;
   localparam int LINE_TOTAL_MIN = 855;
   localparam int LINE_TOTAL_MAX = 1200;
   localparam int FRAME_ACTIVE_LINES = 480;
   localparam int FRAME_TOTAL_LINES = 520;
   localparam int FRAME_TOTAL_MIN = 492;
   localparam int FRAME_TOTAL_MAX = 750;
   localparam int FRAME_RATE_MIN_HZ = 55;
   localparam int FRAME_RATE_MAX_HZ = 65;
   localparam int PIXEL_RATE_MAX_HZ = 29_470_000;
   // 100 MHz / 4 = 25 MHz, inside the allowed pixel clock band
   localparam int PIXEL_DIV = 4;
   localparam int DIV_W = 4;
   localparam int H_CNT_W = 11;
   localparam int V_CNT_W = 10;
   localparam int PIXEL_W = 24;
   localparam int FIFO_DEPTH = 16;

   // ************************************************************
   // power sequence times in ms and their cycle counts
   // ************************************************************
   localparam int SIG_VALID_MAX_MS = 50;
   localparam int RESET_DELAY_MS = 10;
   localparam int WAKE_DELAY_MS = 20;
   localparam int BACKLIGHT_DELAY_MS = 140;
   localparam int BL_OFF_TO_WAKE_OFF_MS = 0;
   localparam int BL_OFF_TO_SIG_OFF_MS = 130;
   localparam int SIG_OFF_TO_SUPPLY_OFF_MS = 0;
   localparam int MIN_SUPPLY_ON_MS = 200;
   localparam int RESET_DELAY_CYC = RESET_DELAY_MS * CYC_PER_MS;
   localparam int WAKE_DELAY_CYC = WAKE_DELAY_MS * CYC_PER_MS;
   localparam int BACKLIGHT_DELAY_CYC = BACKLIGHT_DELAY_MS * CYC_PER_MS;
   localparam int SIG_HOLD_CYC = BL_OFF_TO_SIG_OFF_MS * CYC_PER_MS;
   // zero-ms gaps still take at least one cycle
   localparam int WAKE_OFF_GAP_CYC = (BL_OFF_TO_WAKE_OFF_MS * CYC_PER_MS < 1) ? 1 :
                                     BL_OFF_TO_WAKE_OFF_MS * CYC_PER_MS;
   localparam int SUPPLY_OFF_GAP_CYC = (SIG_OFF_TO_SUPPLY_OFF_MS * CYC_PER_MS < 1) ? 1 :
                                       SIG_OFF_TO_SUPPLY_OFF_MS * CYC_PER_MS;
   localparam int TIMER_W = 25;

   // ************************************************************
   // sequencer states, one-hot
   // ************************************************************
   typedef enum logic [8:0] {
      S_OFF        = 9'h001,
      S_WAIT_GOOD  = 9'h002,
      S_RESET_WAIT = 9'h004,
      S_WAKE_WAIT  = 9'h008,
      S_BL_WAIT    = 9'h010,
      S_ON         = 9'h020,
      S_BL_OFF     = 9'h040,
      S_SIG_HOLD   = 9'h080,
      S_SUPPLY_OFF = 9'h100
   } seq_state_t;

   // panel control pins
   typedef struct packed {
      logic supply_en;
      logic reset_n;
      logic panel_wake_n_input;
      logic backlight_en;
   } panel_ctrl_t;

   // pixel link before the serialiser
   typedef struct packed {
      logic pixel_clk;
      logic pixel_valid_strobe;
      logic [PIXEL_W-1:0] data;
   } video_link_t;

   // whole state of the sequencer and timing generator
   typedef struct packed {
      seq_state_t st;
      logic [TIMER_W-1:0] timer;
      panel_ctrl_t pins;
      logic sig_en;
      logic pgood_s1;
      logic pgood_s2;
      logic [DIV_W-1:0] div;
      logic [H_CNT_W-1:0] hcnt;
      logic [V_CNT_W-1:0] vcnt;
      video_link_t link;
      logic underrun;
      logic frame_start;
   } host_state_t;

endpackage

// File: src/pixel_fifo.sv
`timescale 1ns/1ps
module pixel_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
   } fifo_state_t;

   fifo_state_t q, d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic full, empty, push, pop;

   // ************************************************************
   // flags and handshakes
   // ************************************************************
   // extra pointer bit tells full from empty
   assign empty = (q.wr == q.rd);
   assign full = (q.wr[AW-1:0] == q.rd[AW-1:0]) && (q.wr[AW] != q.rd[AW]);
   assign o_in_ready = !full;
   assign o_out_valid = !empty;
   assign push = i_in_valid && !full;
   assign pop = i_out_ready && !empty;
   assign o_out_data = mem[q.rd[AW-1:0]];

   // pointer update, wraps at DEPTH
   always_comb begin
      d = q;
      if (push) begin
         d.wr = (q.wr[AW-1:0] == AW'(DEPTH - 1)) ? {~q.wr[AW], {AW{1'b0}}} : q.wr + 1'b1;
      end
      if (pop) begin
         d.rd = (q.rd[AW-1:0] == AW'(DEPTH - 1)) ? {~q.rd[AW], {AW{1'b0}}} : q.rd + 1'b1;
      end
      if (i_rst) begin
         d = '0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      q <= d;
   end

   // storage has no reset; empty flag guards stale words
   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem[q.wr[AW-1:0]] <= i_in_data;
      end
   end

endmodule // pixel_fifo

// File: src/panel_video_timing_power_seq.sv
`timescale 1ns/1ps
// Functional notes
// R1 - pixel clock stays within 24.94 to 29.47 MHz, near 27.21 typical.
// R2 - each line is 855 to 1200 clocks, exactly 800 with strobe high.
// R3 - each frame is 492 to 750 lines, exactly 480 carrying pixels.
// R4 - frame rate kept between 55 and 65 Hz, 60 Hz reference.
// R5 - line total times frame total times frame rate at most 29.47 MHz.
// R6 - pixels framed only by the valid strobe, no separate sync pins.
// R7 - every driven signal held low while panel supply is off.
// R8 - supply kept on over 200 ms after power-up before removal.
// R9 - interface signals valid within 50 ms after supply good.
// R10 - reset released high at least 10 ms after supply good.
// R11 - wake input raised at least 20 ms after reset release.
// R12 - backlight on no earlier than 140 ms after wake input rises.
// R13 - backlight off no later than wake input returning low.
// R14 - signals keep running at least 130 ms after backlight off.
// R15 - signals stopped no later than the supply starts to fall.
// R16 - panel controller held in reset while its reset input is low.
// R17 - panel controller and source driver off while wake input low.
module panel_video_timing_power_seq import panel_host_pkg::*; #(
   parameter int PIX_DIV = PIXEL_DIV,
   parameter int LINE_TOTAL = LINE_TOTAL_CLOCKS,
   parameter int LINE_ACTIVE = LINE_ACTIVE_CLOCKS,
   parameter int FRAME_TOTAL = FRAME_TOTAL_LINES,
   parameter int FRAME_ACTIVE = FRAME_ACTIVE_LINES,
   parameter int FIFO_WORDS = FIFO_DEPTH,
   parameter int RESET_CYC = RESET_DELAY_CYC,
   parameter int WAKE_CYC = WAKE_DELAY_CYC,
   parameter int BACKLIGHT_CYC = BACKLIGHT_DELAY_CYC,
   parameter int HOLD_CYC = SIG_HOLD_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_power_req,
   input wire logic i_supply_good,
   input wire logic i_pix_valid,
   output logic o_pix_ready,
   input wire logic [PIXEL_W-1:0] i_pix_data,
   output panel_ctrl_t o_panel,
   output video_link_t o_link,
   output logic o_panel_on,
   output logic o_frame_start,
   output logic o_underrun
);

   localparam int HALF = PIX_DIV / 2;
   // pix_div must be even and at least two, or the
   // pixel clock loses its equal high and low halves;
   // the default of four gives two cycles each way

   // the long delays are in core cycles so that a
   // bench may shrink them; the timer is wide enough
   // for the longest default wait without wrapping

   host_state_t q, d;
   logic fifo_valid;
   logic fifo_pop;
   logic [PIXEL_W-1:0] fifo_data;
   logic tick;
   logic [H_CNT_W-1:0] h_next;
   logic [V_CNT_W-1:0] v_next;
   logic active_next;
   logic powered;

   // ************************************************************
   // pixel buffer between source and link
   // ************************************************************
   // source stalls on o_pix_ready; drain only in active slots
   // sixteen words cover a short source hiccup only;
   // a source slower than the pixel rate will starve
   // the raster and see underrun pulses each line
   // the buffer is cleared by reset, not by power-down,
   // so words queued before power-up are sent first
   pixel_fifo #(
      .WIDTH(PIXEL_W),
      .DEPTH(FIFO_WORDS)
   ) u_pixel_fifo (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_in_valid(i_pix_valid),
      .o_in_ready(o_pix_ready),
      .i_in_data(i_pix_data),
      .o_out_valid(fifo_valid),
      .i_out_ready(fifo_pop),
      .o_out_data(fifo_data)
   );

   // ************************************************************
   // raster position of the next pixel slot
   // ************************************************************
   // one pixel slot per divider period, advanced as the clock falls
   // the position is worked out one slot ahead so
   // that the buffer word can be fetched in the
   // same cycle the strobe and data are launched;
   // data then settles a half period before the
   // rising edge the panel samples on
   // counters start at the last slot so the first
   // tick after link start lands on pixel (0,0)
   always_comb begin
      tick = q.sig_en && (q.div == DIV_W'(HALF - 1)); // R1
      if (q.hcnt == H_CNT_W'(LINE_TOTAL - 1)) begin
         h_next = '0; // R2
         v_next = (q.vcnt == V_CNT_W'(FRAME_TOTAL - 1)) ? '0 : q.vcnt + 1'b1; // R3
      end else begin
         h_next = q.hcnt + 1'b1;
         v_next = q.vcnt;
      end
      // strobe is the only framing the panel sees
      active_next = (h_next < H_CNT_W'(LINE_ACTIVE)) && (v_next < V_CNT_W'(FRAME_ACTIVE)); // R6
      fifo_pop = tick && active_next;
   end

   // supply was seen good and the sequencer is past the rise
   // the wait for supply good is left out on purpose:
   // a slow supply there is not a loss of supply,
   // and the shut-down state must not restart itself
   assign powered = (q.st != S_OFF) && (q.st != S_WAIT_GOOD) && (q.st != S_SUPPLY_OFF);

   // ************************************************************
   // power sequencer and timing generator
   // ************************************************************
   // each timed state waits on the shared timer, which is
   // cleared on every state change; waits compare
   // with >= so a timer that saturates cannot hang
   // a state, and each step moves one pin only
   // a request that drops during the rise is held
   // off until the panel is fully on, so the panel
   // never sees a half-finished sequence
   always_comb begin
      d = q;
      // supply monitor is an outside pin, two flops before use
      d.pgood_s1 = i_supply_good;
      d.pgood_s2 = q.pgood_s1;
      d.underrun = 1'b0;
      d.frame_start = 1'b0;
      // saturating cycle counter since state entry
      d.timer = (q.timer == {TIMER_W{1'b1}}) ? q.timer : q.timer + 1'b1;

      case (q.st)
         S_OFF: begin
            d.pins = '0; // R7
            d.sig_en = 1'b0; // R7
            if (i_power_req) begin
               d.pins.supply_en = 1'b1;
               d.timer = '0;
               d.st = S_WAIT_GOOD;
            end
         end
         S_WAIT_GOOD: begin
            // signals start in the same cycle supply good is seen
            if (q.pgood_s2) begin
               d.sig_en = 1'b1; // R9
               d.timer = '0;
               d.st = S_RESET_WAIT;
            end
         end
         S_RESET_WAIT: begin
            if (q.timer >= TIMER_W'(RESET_CYC - 1)) begin
               d.pins.reset_n = 1'b1; // R10 R16
               d.timer = '0;
               d.st = S_WAKE_WAIT;
            end
         end
         S_WAKE_WAIT: begin
            if (q.timer >= TIMER_W'(WAKE_CYC - 1)) begin
               d.pins.panel_wake_n_input = 1'b1; // R11 R17
               d.timer = '0;
               d.st = S_BL_WAIT;
            end
         end
         S_BL_WAIT: begin
            if (q.timer >= TIMER_W'(BACKLIGHT_CYC - 1)) begin
               d.pins.backlight_en = 1'b1; // R12
               d.timer = '0;
               d.st = S_ON;
            end
         end
         S_ON: begin
            // requested power-down only from here: 170 ms on plus 130 ms hold
            // already keeps the supply up well past its minimum
            if (!i_power_req) begin // R8
               d.pins.backlight_en = 1'b0; // R13
               d.timer = '0;
               d.st = S_BL_OFF;
            end
         end
         S_BL_OFF: begin
            if (q.timer >= TIMER_W'(WAKE_OFF_GAP_CYC - 1)) begin
               d.pins.panel_wake_n_input = 1'b0; // R13
               d.timer = '0;
               d.st = S_SIG_HOLD;
            end
         end
         S_SIG_HOLD: begin
            // counted from wake off, so the gap from backlight off is longer
            if (q.timer >= TIMER_W'(HOLD_CYC - 1)) begin
               d.sig_en = 1'b0; // R14
               d.pins.reset_n = 1'b0; // R15
               d.timer = '0;
               d.st = S_SUPPLY_OFF;
            end
         end
         S_SUPPLY_OFF: begin
            if (q.timer >= TIMER_W'(SUPPLY_OFF_GAP_CYC - 1)) begin
               d.pins.supply_en = 1'b0; // R15
               d.timer = '0;
               d.st = S_OFF;
            end
         end
         default: begin
            d.pins = '0;
            d.sig_en = 1'b0;
            d.st = S_OFF;
         end
      endcase

      // this override comes after the case so it wins
      // over any step the sequencer took this cycle;
      // the supply enable itself is dropped one cycle
      // later by the shut-down state
      // supply lost while powered: drop every pin but the supply enable at once,
      // the panel is dark anyway and must not be back-driven
      if (powered && !q.pgood_s2) begin
         d.pins.backlight_en = 1'b0; // R7
         d.pins.panel_wake_n_input = 1'b0; // R7
         d.pins.reset_n = 1'b0; // R7
         d.sig_en = 1'b0; // R7
         d.timer = '0;
         d.st = S_SUPPLY_OFF;
      end

      // link runs only while signals are enabled
      // the next value of sig_en is used here so the
      // link starts and stops in the very cycle the
      // sequencer decides, with no stray half period
      // a stop may cut a pixel clock period short;
      // the panel is being shut down at that point
      if (!d.sig_en) begin
         d.div = '0;
         d.hcnt = H_CNT_W'(LINE_TOTAL - 1);
         d.vcnt = V_CNT_W'(FRAME_TOTAL - 1);
         d.link = '0; // R7 R15
      end else begin
         // divider makes the pixel clock; no second clock domain
         d.div = (q.div == DIV_W'(PIX_DIV - 1)) ? '0 : q.div + 1'b1; // R1
         d.link.pixel_clk = (d.div < DIV_W'(HALF)); // R1
         if (tick) begin
            d.hcnt = h_next;
            d.vcnt = v_next;
            d.link.pixel_valid_strobe = active_next; // R2 R3 R6
            d.frame_start = (h_next == '0) && (v_next == '0);
            if (active_next) begin
               // an empty buffer sends black rather than stalling the raster
               d.link.data = fifo_valid ? fifo_data : '0;
               d.underrun = !fifo_valid;
            end else begin
               d.link.data = '0;
            end
         end
      end

      // reset wins over everything above; the raster
      // counters go to their parked values, not zero
      if (i_rst) begin
         d = '0;
         d.st = S_OFF;
         d.hcnt = H_CNT_W'(LINE_TOTAL - 1);
         d.vcnt = V_CNT_W'(FRAME_TOTAL - 1);
      end
   end

   always_ff @(posedge i_core_clk) begin
      q <= d;
   end

   // ************************************************************
   // outputs, all from flops
   // ************************************************************
   assign o_panel = q.pins;
   assign o_link = q.link;
   assign o_panel_on = (q.st == S_ON);
   assign o_frame_start = q.frame_start;
   assign o_underrun = q.underrun;

   // the panel sees levels only; nothing here drives
   // a pin high while the supply enable is low
   // frame start and underrun are single-cycle
   // pulses for a local monitor, not panel pins

   // defaults give 25 MHz, 872 x 520, about 55.1 Hz: R4 R5 hold
   // only if overriding parameters keep within the same bands

endmodule // panel_video_timing_power_seq

// File: testbench/panel_video_timing_power_seq_properties.sv
`timescale 1ns/1ps
module panel_seq_properties import panel_host_pkg::*; #(
   parameter int LINE_ACTIVE = LINE_ACTIVE_CLOCKS,
   parameter int RESET_CYC = RESET_DELAY_CYC,
   parameter int WAKE_CYC = WAKE_DELAY_CYC,
   parameter int BACKLIGHT_CYC = BACKLIGHT_DELAY_CYC,
   parameter int HOLD_CYC = SIG_HOLD_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_supply_good,
   input wire panel_ctrl_t o_panel,
   input wire video_link_t o_link
);
   // ********************
   // helper counters
   // ********************
   int good_q, rst_q, wake_q, bl_off_q, act_q;
   logic pclk_q;
   logic pclk_rise;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   assign pclk_rise = o_link.pixel_clk && !pclk_q;
   // plain int counters, test runs are far too short to wrap them
   always_ff @(posedge i_core_clk) begin
      good_q <= i_supply_good ? good_q + 1 : 0;
      rst_q <= o_panel.reset_n ? rst_q + 1 : 0;
      wake_q <= o_panel.panel_wake_n_input ? wake_q + 1 : 0;
      bl_off_q <= o_panel.backlight_en ? 0 : bl_off_q + 1;
      pclk_q <= o_link.pixel_clk;
      if (!o_panel.supply_en) begin
         act_q <= 0;
      end else if (pclk_rise) begin
         act_q <= o_link.pixel_valid_strobe ? act_q + 1 : 0;
      end
   end
   // ********************
   // sequencing and link
   // ********************
   AST_RESET_DELAY: assert property ($rose(o_panel.reset_n) |-> good_q >= RESET_CYC)
      else $error("reset released early");
   AST_WAKE_DELAY: assert property ($rose(o_panel.panel_wake_n_input) |-> rst_q >= WAKE_CYC)
      else $error("wake raised early");
   AST_BL_DELAY: assert property ($rose(o_panel.backlight_en) |-> wake_q >= BACKLIGHT_CYC)
      else $error("backlight on early");
   AST_BL_BEFORE_WAKE: assert property (o_panel.backlight_en |-> o_panel.panel_wake_n_input)
      else $error("backlight on without wake");
   AST_SIG_HOLD: assert property ($fell(o_panel.reset_n) |-> bl_off_q > HOLD_CYC)
      else $error("link stopped early");
   AST_OFF_QUIET: assert property (!o_panel.supply_en |-> o_link == '0 && o_panel == '0)
      else $error("signal driven without supply");
   AST_SIG_VALID: assert property ($rose(i_supply_good) && o_panel.supply_en |-> ##[1:5] o_link.pixel_clk)
      else $error("link late after supply good");
   AST_PCLK_SHAPE: assert property ($rose(o_link.pixel_clk) && o_panel.backlight_en |->
      o_link.pixel_clk [*2] ##1 !o_link.pixel_clk [*2] ##1 o_link.pixel_clk)
      else $error("pixel clock shape");
   AST_RISE_STABLE: assert property (pclk_rise |->
      $stable(o_link.data) && $stable(o_link.pixel_valid_strobe))
      else $error("link changed at clock rise");
   AST_LINE_ACTIVE: assert property (pclk_rise && !o_link.pixel_valid_strobe && act_q != 0 |->
      act_q == LINE_ACTIVE)
      else $error("active slot count");
   COV_ON: cover property ($rose(o_panel.backlight_en));
   COV_OFF: cover property ($fell(o_panel.supply_en));
   COV_PIXEL: cover property (pclk_rise && o_link.pixel_valid_strobe);
endmodule // panel_seq_properties

bind panel_video_timing_power_seq panel_seq_properties #(
   .LINE_ACTIVE(LINE_ACTIVE),
   .RESET_CYC(RESET_CYC),
   .WAKE_CYC(WAKE_CYC),
   .BACKLIGHT_CYC(BACKLIGHT_CYC),
   .HOLD_CYC(HOLD_CYC)
) panel_seq_properties_inst (
   .i_core_clk(i_core_clk),
   .i_rst(i_rst),
   .i_supply_good(i_supply_good),
   .o_panel(o_panel),
   .o_link(o_link)
);

// File: testbench/panel_model.sv
`timescale 1ns/1ps
module panel_model import panel_host_pkg::*; #(
   parameter int GOOD_DLY = 2
) (
   input wire logic i_core_clk,
   input wire panel_ctrl_t i_panel,
   input wire video_link_t i_link,
   output logic o_supply_good,
   output int o_pix_cnt,
   output int o_gaps,
   output logic [PIXEL_W-1:0] o_last_pix
);
   // ********************
   // panel behaviour
   // ********************
   int ramp_q;
   logic pclk_q = 1'b0;
   initial o_supply_good = 1'b0;
   // supply ramps a few cycles before good, drops at once when cut
   always @(posedge i_core_clk) begin
      ramp_q <= i_panel.supply_en ? ramp_q + 1 : 0;
      o_supply_good <= i_panel.supply_en && ramp_q >= GOOD_DLY;
      pclk_q <= i_link.pixel_clk;
      // pixels only taken out of reset and awake, framed by strobe alone
      if (i_link.pixel_clk && !pclk_q && i_link.pixel_valid_strobe && i_panel.reset_n &&
         i_panel.panel_wake_n_input) begin
         if (o_pix_cnt != 0 && i_link.data !== o_last_pix + 1'b1) begin
            o_gaps <= o_gaps + 1;
         end
         o_pix_cnt <= o_pix_cnt + 1;
         o_last_pix <= i_link.data;
      end
   end
endmodule // panel_model

// File: testbench/panel_video_timing_power_seq_bench.sv
`timescale 1ns/1ps
module panel_video_timing_power_seq_bench import panel_host_pkg::*;;
   // small geometry and delays keep the run short
   localparam int LT = 12, LA = 8, FT = 6, FA = 4;
   localparam int RC = 5, WC = 7, BC = 9, HC = 11;
   localparam int FRAME_CYC = LT * FT * PIXEL_DIV;
   logic core_clk = 1'b0, rst = 1'b1, power_req = 1'b0, src_on = 1'b0;
   logic pix_valid = 1'b0, good_q = 1'b0;
   logic [PIXEL_W-1:0] pix_data = 24'h000001;
   logic [PIXEL_W-1:0] last_pix;
   logic supply_good, pix_ready, panel_on, frame_start, underrun;
   panel_ctrl_t panel, pp;
   video_link_t link;
   int pix_cnt, gaps, cyc, accepted, under_cnt, c0, t_good, t_fs, fs_gap;
   int t_up[4], t_dn[4];
   int t_link = -1, fails = 0, cmp_count = 0;
   always #5 core_clk = ~core_clk;
   panel_video_timing_power_seq #(.LINE_TOTAL(LT), .LINE_ACTIVE(LA), .FRAME_TOTAL(FT),
      .FRAME_ACTIVE(FA), .RESET_CYC(RC), .WAKE_CYC(WC), .BACKLIGHT_CYC(BC), .HOLD_CYC(HC))
      panel_video_timing_power_seq_inst (.i_core_clk(core_clk), .i_rst(rst),
      .i_power_req(power_req), .i_supply_good(supply_good), .i_pix_valid(pix_valid),
      .o_pix_ready(pix_ready), .i_pix_data(pix_data), .o_panel(panel), .o_link(link),
      .o_panel_on(panel_on), .o_frame_start(frame_start), .o_underrun(underrun));
   panel_model panel_model_inst (.i_core_clk(core_clk), .i_panel(panel), .i_link(link),
      .o_supply_good(supply_good), .o_pix_cnt(pix_cnt), .o_gaps(gaps), .o_last_pix(last_pix));
   // ********************
   // edge stamps and pixel source
   // ********************
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      pp <= panel;
      good_q <= supply_good;
      for (int b = 0; b < 4; b++) begin
         if (panel[b] === 1'b1 && pp[b] === 1'b0) t_up[b] = cyc;
         if (panel[b] === 1'b0 && pp[b] === 1'b1) t_dn[b] = cyc;
      end
      if (supply_good === 1'b1 && good_q === 1'b0) t_good = cyc;
      if (link.pixel_clk === 1'b1 && t_link < 0) t_link = cyc;
      if (frame_start === 1'b1) begin
         fs_gap = cyc - t_fs;
         t_fs = cyc;
      end
      if (underrun === 1'b1) under_cnt++;
      // source holds word until taken, valid follows src_on
      if (pix_valid && pix_ready === 1'b1) begin
         pix_data <= pix_data + 1'b1;
         accepted++;
      end
      pix_valid <= src_on;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ********************
   // scenarios
   // ********************
   // default geometry and delays judged against the bands, too long to run
   task automatic t_limits;
      int rate;
      int on_cyc;
      rate = CORE_CLK_HZ / (PIXEL_DIV * LINE_TOTAL_CLOCKS * FRAME_TOTAL_LINES);
      on_cyc = RESET_DELAY_CYC + WAKE_DELAY_CYC + BACKLIGHT_DELAY_CYC + SIG_HOLD_CYC;
      chk(rate >= FRAME_RATE_MIN_HZ && rate <= FRAME_RATE_MAX_HZ, 1, "frame rate");
      chk(LINE_TOTAL_CLOCKS * FRAME_TOTAL_LINES * rate <= PIXEL_RATE_MAX_HZ, 1, "pixel rate");
      chk(on_cyc >= MIN_SUPPLY_ON_MS * CYC_PER_MS, 1, "supply on time");
      $display("limits done");
   endtask
   task automatic t_fill;
      src_on <= 1'b1;
      repeat (24) @(posedge core_clk);
      chk(accepted, FIFO_DEPTH, "fifo fill");
      chk(pix_ready, 0, "fifo refuses");
      chk({panel, link}, 0, "quiet before supply");
      $display("fill done");
   endtask
   task automatic t_power_up;
      power_req <= 1'b1;
      for (int i = 0; i < 300 && panel_on !== 1'b1; i++) @(posedge core_clk);
      repeat (2) @(posedge core_clk);
      chk(t_link - t_good, 3, "signal valid");
      chk(t_up[2] - t_good, RC + 3, "reset release");
      chk(t_up[1] - t_up[2], WC, "wake delay");
      chk(t_up[0] - t_up[1], BC, "backlight delay");
      $display("power up done");
   endtask
   task automatic t_stream;
      repeat (FRAME_CYC) @(posedge core_clk);
      c0 = pix_cnt;
      repeat (FRAME_CYC) @(posedge core_clk);
      chk(pix_cnt - c0, LA * FA, "pixels per frame");
      chk(fs_gap, FRAME_CYC, "frame period");
      chk(gaps, 0, "raster order");
      chk(under_cnt, 0, "no underrun");
      $display("stream done");
   endtask
   task automatic t_underrun;
      src_on <= 1'b0;
      c0 = pix_cnt;
      repeat (FRAME_CYC) @(posedge core_clk);
      chk(pix_cnt - c0, LA * FA, "strobe while starved");
      chk(under_cnt >= LA * FA - FIFO_DEPTH, 1, "underrun seen");
      src_on <= 1'b1;
      $display("underrun done");
   endtask
   task automatic t_power_down;
      power_req <= 1'b0;
      for (int i = 0; i < 100 && panel.supply_en !== 1'b0; i++) @(posedge core_clk);
      repeat (2) @(posedge core_clk);
      chk(t_dn[1] - t_dn[0], 1, "backlight before wake");
      chk(t_dn[2] - t_dn[0], HC + 1, "signal hold");
      chk(t_dn[3] - t_dn[2], 1, "supply after signals");
      chk({panel, link, panel_on}, 0, "quiet after supply");
      $display("power down done");
   endtask
   initial begin
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      t_limits();
      t_fill();
      t_power_up();
      t_stream();
      t_underrun();
      t_power_down();
      wrap_up();
   end
   // about 1000 cycles expected, five times that is a hang
   initial begin
      #50000;
      fails++;
      wrap_up();
   end
endmodule // panel_video_timing_power_seq_bench
